// ### inc/mcd_pkg.sv
// constants and types for the microcycle clock and datapath block
// assumes a single 20 MHz clock; lengths are given in ns and converted to cycles of that clock
package mcd_pkg;
  localparam int unsigned CLK_MHZ        = 20;
  localparam int unsigned UADDR_W        = 9;
  localparam int unsigned WORD_W         = 16;
  localparam int unsigned BA_W           = 18;
  localparam int unsigned DRV_W          = 18;
  // cycle length in ns for the three selectable lengths
  localparam int unsigned LEN_SHORT_NS   = 150;
  localparam int unsigned LEN_MED_NS     = 200;
  localparam int unsigned LEN_LONG_NS    = 300;
  localparam int unsigned LEN_SHORT_CYC  = (LEN_SHORT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned LEN_MED_CYC    = (LEN_MED_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned LEN_LONG_CYC   = (LEN_LONG_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W          = 4;
  // self addresses of the processor's own registers
  localparam logic [17:0] ADDR_STATUS    = 18'h3FFFE;
  localparam logic [17:0] ADDR_SLIMIT    = 18'h3FFFA;
  localparam logic [17:0] ADDR_SWITCH    = 18'h3FF78;
  localparam logic [17:0] ADDR_SPAD_BASE = 18'h3FF00;
  localparam logic [17:0] ADDR_SPAD_MASK = 18'h3FFF0;
  localparam logic [15:0] STACK_FLOOR    = 16'h0100;
  localparam logic [15:0] STACK_WARN     = 16'h0020;
  localparam logic [15:0] RST_WORD       = 16'h0000;
  localparam logic [8:0]  RST_UADDR      = 9'h000;
  localparam logic [1:0]  SEL_REGBUS     = 2'h0;
  localparam logic [1:0]  SEL_RESULT     = 2'h1;
  localparam logic [1:0]  SEL_SHIFT      = 2'h2;
  localparam logic [1:0]  SEL_SYSBUS     = 2'h3;
  typedef enum logic [1:0] {
    MCD_IDLE  = 2'b00,
    MCD_RUN   = 2'b01,
    MCD_DRAIN = 2'b11
  } mcd_state_e;
endpackage : mcd_pkg

// ### hw/mcd_pulse_gen.sv
// three-phase pulse generator for one microcycle of selectable length
// assumes start is raised only while idle or on the last count, where it restarts the cycle
`timescale 1ns/1ps
module mcd_pulse_gen
  import mcd_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       start,
  input  wire logic [1:0] len_sel,
  output logic            busy,
  output logic            pulse_first,
  output logic            pulse_second,
  output logic            pulse_third,
  output logic            next_trigger
);
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] len_ff;
  logic             busy_ff;
  logic [CNT_W-1:0] nxt_len;

  always_comb
  begin
    case (len_sel)
      2'b00:   nxt_len = CNT_W'(LEN_SHORT_CYC);
      2'b01:   nxt_len = CNT_W'(LEN_MED_CYC);
      default: nxt_len = CNT_W'(LEN_LONG_CYC);
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_ff  <= '0;
      len_ff  <= '0;
      busy_ff <= 1'b0;
    end
    else if (start && (!busy_ff || cnt_ff == len_ff))
    begin
      cnt_ff  <= 4'h1;
      len_ff  <= nxt_len;
      busy_ff <= 1'b1;
    end
    else if (busy_ff)
    begin
      if (cnt_ff == len_ff)
        busy_ff <= 1'b0;
      cnt_ff <= cnt_ff + 4'h1;
    end
  end

  // pulses fall on the first, middle and last cycle so their order is fixed
  assign busy         = busy_ff;
  assign pulse_first  = busy_ff && (cnt_ff == 4'h1);
  assign pulse_second = busy_ff && (cnt_ff == (len_ff >> 1) + 4'h1);
  assign pulse_third  = busy_ff && (cnt_ff == len_ff);
  assign next_trigger = pulse_third;
endmodule : mcd_pulse_gen

// ### hw/mcd_core.sv
// microcycle clock control plus result/address/instruction datapath
// assumes microword fields are stable for the whole microcycle and that
// console switches and restart/continue come from pins (synchronised here)
//
// Summary of operation
// - match is high only when all nine microaddress bits equal switch bits
// - in maintenance mode a match halts the clock; otherwise a scope sync
// - running and idle flops; halt bit stops, restart or continue resumes
// - two length bits pick one of three microcycle lengths
// - three ordered pulses per cycle, trigger starts the next cycle
// - destination clocks come from a pulse gated by microword enables
// - separate enables for holder, address, B, result, scratch writes
// - two-bit field selects register bus, result, shifted result, or bus data
// - selector output feeds holder, scratch, B, status, display, option bus
// - result register loads ALU output and drives selector and bus data
// - display shows the inverted selector output
// - eighteen-bit address decoded to status, limit, scratch, switch selects
// - decoder raises overflow stop and overflow warning
// - zero detect whenever the result register is all zeros
// - nine buffers drive microaddress to history and match; expansion port registers the pointer directly
// - instruction holder loads from selector during fetch
// - past microaddress captures the pointer every microcycle
`timescale 1ns/1ps
module mcd_core
  import mcd_pkg::*;
(
  input  wire logic [8:0]  microaddress_pointer,
  input  wire logic [15:0] console_switch_word,
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        maint_mode,
  input  wire logic        restart_req,
  input  wire logic        continue_req,
  input  wire logic        microword_clock_halt,
  input  wire logic        cycle_length_bit0,
  input  wire logic        cycle_length_bit1,
  input  wire logic        instr_holder_clock_enable,
  input  wire logic        bus_address_clock_enable,
  input  wire logic        b_operand_clock_enable,
  input  wire logic        result_clock_enable,
  input  wire logic        scratch_write_high_byte,
  input  wire logic        scratch_write_low_byte,
  input  wire logic [1:0]  result_sel,
  input  wire logic [15:0] reg_read_bus,
  input  wire logic [15:0] alu_out,
  input  wire logic [15:0] sys_bus_data_in,
  input  wire logic [17:0] bus_address,
  input  wire logic [15:0] stack_pointer,
  input  wire logic        stack_check,
  input  wire logic [8:0]  expansion_hi_bits,
  output logic             match_ff,
  output logic             scope_sync_ff,
  output logic             running_ff,
  output logic             idle_ff,
  output logic             timing_pulse_first_ff,
  output logic             timing_pulse_second_ff,
  output logic             timing_pulse_third_ff,
  output logic             next_cycle_trigger_ff,
  output logic             clk_instr_ff,
  output logic             clk_bus_address_ff,
  output logic             clk_b_operand_ff,
  output logic             clk_result_ff,
  output logic             wr_scratch_high_ff,
  output logic             wr_scratch_low_ff,
  output logic [15:0]      result_selector_ff,
  output logic [15:0]      result_reg_ff,
  output logic [15:0]      sys_bus_data_out_ff,
  output logic [15:0]      data_display_ff,
  output logic             sel_status_ff,
  output logic             sel_stack_limit_ff,
  output logic             sel_scratch_ff,
  output logic             sel_switch_ff,
  output logic             stack_overflow_stop_ff,
  output logic             stack_overflow_flag_ff,
  output logic             result_zero_ff,
  output logic [8:0]       buffered_microaddress_ff,
  output logic [17:0]      expansion_microaddress_ff,
  output logic [8:0]       past_microaddress_ff,
  output logic [15:0]      instruction_holder_ff,
  output logic [2:0]       instr_branch_bits_ff,
  output logic [3:0]       instr_scratch_sel_ff
);
  import mcd_pkg::*;

  mcd_state_e       state_ff;
  mcd_state_e       nxt_state;
  logic [1:0]       maint_sync_ff;
  logic [1:0]       restart_sync_ff;
  logic [1:0]       cont_sync_ff;
  logic [UADDR_W-1:0] sw_sync1_ff;
  logic [UADDR_W-1:0] sw_sync2_ff;
  logic             restart_d_ff;
  logic             cont_d_ff;
  logic             resume;
  logic             stop_pending_ff;
  logic             start_pulse;
  logic             gen_busy;
  logic             p_first;
  logic             p_second;
  logic             p_third;
  logic             p_trig;
  logic [8:0]       eq_bits;
  logic             match_now;
  logic [15:0]      nxt_select;

  // pins pass two flops; the second stage is read, and restart/continue also feed a third flop for edge detect
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      maint_sync_ff   <= 2'h0;
      restart_sync_ff <= 2'h0;
      cont_sync_ff    <= 2'h0;
      sw_sync1_ff     <= RST_UADDR;
      sw_sync2_ff     <= RST_UADDR;
      restart_d_ff    <= 1'b0;
      cont_d_ff       <= 1'b0;
    end
    else
    begin
      maint_sync_ff   <= {maint_sync_ff[0], maint_mode};
      restart_sync_ff <= {restart_sync_ff[0], restart_req};
      cont_sync_ff    <= {cont_sync_ff[0], continue_req};
      sw_sync1_ff     <= console_switch_word[8:0];
      sw_sync2_ff     <= sw_sync1_ff;
      restart_d_ff    <= restart_sync_ff[1];
      cont_d_ff       <= cont_sync_ff[1];
    end
  end

  assign resume = (restart_sync_ff[1] && !restart_d_ff) ||
                  (cont_sync_ff[1] && !cont_d_ff);

  // per-bit equivalence, then all must agree
  genvar gi;
  generate
    for (gi = 0; gi < UADDR_W; gi++)
    begin : g_eq
      assign eq_bits[gi] = ~(buffered_microaddress_ff[gi] ^ sw_sync2_ff[gi]);
    end
  endgenerate
  assign match_now = &eq_bits;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      match_ff      <= 1'b0;
      scope_sync_ff <= 1'b0;
    end
    else
    begin
      match_ff      <= match_now;
      scope_sync_ff <= match_now && !maint_sync_ff[1];
    end
  end

  // a stop request is remembered until the cycle's last pulse has passed
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      stop_pending_ff <= 1'b0;
    else if (state_ff == MCD_RUN && gen_busy &&
             (microword_clock_halt || (maint_sync_ff[1] && match_now)))
      stop_pending_ff <= 1'b1;
    else if (state_ff != MCD_RUN)
      stop_pending_ff <= 1'b0;
  end

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      MCD_IDLE:
        if (resume)
          nxt_state = MCD_RUN;
      MCD_RUN:
        if (p_trig && stop_pending_ff)
          nxt_state = MCD_DRAIN;
      MCD_DRAIN:
        if (!gen_busy)
          nxt_state = MCD_IDLE;
      default:
        nxt_state = MCD_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_ff <= MCD_IDLE;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      running_ff <= 1'b0;
      idle_ff    <= 1'b1;
    end
    else
    begin
      running_ff <= (nxt_state == MCD_RUN);
      idle_ff    <= (nxt_state == MCD_IDLE);
    end
  end

  // the trigger restarts the generator itself so no idle clock stretches the cycle
  assign start_pulse = state_ff == MCD_RUN && (!gen_busy || p_trig && !stop_pending_ff);

  mcd_pulse_gen u_pulse
  (
    .clk          (clk),
    .rst_n        (rst_n),
    .start        (start_pulse),
    .len_sel      ({cycle_length_bit1, cycle_length_bit0}),
    .busy         (gen_busy),
    .pulse_first  (p_first),
    .pulse_second (p_second),
    .pulse_third  (p_third),
    .next_trigger (p_trig)
  );

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timing_pulse_first_ff  <= 1'b0;
      timing_pulse_second_ff <= 1'b0;
      timing_pulse_third_ff  <= 1'b0;
      next_cycle_trigger_ff  <= 1'b0;
    end
    else
    begin
      timing_pulse_first_ff  <= p_first;
      timing_pulse_second_ff <= p_second;
      timing_pulse_third_ff  <= p_third;
      next_cycle_trigger_ff  <= p_trig;
    end
  end

  // destination strobes all taken from the third pulse so data is settled
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clk_instr_ff       <= 1'b0;
      clk_bus_address_ff <= 1'b0;
      clk_b_operand_ff   <= 1'b0;
      clk_result_ff      <= 1'b0;
      wr_scratch_high_ff <= 1'b0;
      wr_scratch_low_ff  <= 1'b0;
    end
    else
    begin
      clk_instr_ff       <= p_third && instr_holder_clock_enable;
      clk_bus_address_ff <= p_third && bus_address_clock_enable;
      clk_b_operand_ff   <= p_third && b_operand_clock_enable;
      clk_result_ff      <= p_third && result_clock_enable;
      wr_scratch_high_ff <= p_third && scratch_write_high_byte;
      wr_scratch_low_ff  <= p_third && scratch_write_low_byte;
    end
  end

  always_comb
  begin
    case (result_sel)
      SEL_REGBUS: nxt_select = reg_read_bus;
      SEL_RESULT: nxt_select = result_reg_ff;
      SEL_SHIFT:  nxt_select = {1'b0, result_reg_ff[15:1]};
      default:    nxt_select = sys_bus_data_in;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      result_selector_ff <= RST_WORD;
      data_display_ff    <= ~RST_WORD;
    end
    else
    begin
      result_selector_ff <= nxt_select;
      data_display_ff    <= ~nxt_select;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      result_reg_ff       <= RST_WORD;
      sys_bus_data_out_ff <= RST_WORD;
      result_zero_ff      <= 1'b1;
    end
    else if (p_third && result_clock_enable)
    begin
      result_reg_ff       <= alu_out;
      sys_bus_data_out_ff <= alu_out;
      result_zero_ff      <= (alu_out == RST_WORD);
    end
  end

  // decode is registered; selects lag the address by one clock
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sel_status_ff          <= 1'b0;
      sel_stack_limit_ff     <= 1'b0;
      sel_scratch_ff         <= 1'b0;
      sel_switch_ff          <= 1'b0;
      stack_overflow_stop_ff <= 1'b0;
      stack_overflow_flag_ff <= 1'b0;
    end
    else
    begin
      sel_status_ff      <= (bus_address == ADDR_STATUS);
      sel_stack_limit_ff <= (bus_address == ADDR_SLIMIT);
      sel_scratch_ff     <= ((bus_address & ADDR_SPAD_MASK) == ADDR_SPAD_BASE);
      sel_switch_ff      <= (bus_address == ADDR_SWITCH);
      // below the floor minus the band is fatal; inside the band just under the floor it only warns
      stack_overflow_stop_ff <= stack_check && (stack_pointer < STACK_FLOOR - STACK_WARN);
      stack_overflow_flag_ff <= stack_check && (stack_pointer < STACK_FLOOR);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      buffered_microaddress_ff  <= RST_UADDR;
      expansion_microaddress_ff <= 18'h00000;
    end
    else
    begin
      buffered_microaddress_ff  <= microaddress_pointer;
      expansion_microaddress_ff <= {expansion_hi_bits, microaddress_pointer};
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      past_microaddress_ff <= RST_UADDR;
    else if (p_trig)
      past_microaddress_ff <= buffered_microaddress_ff;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      instruction_holder_ff <= RST_WORD;
      instr_branch_bits_ff  <= 3'h0;
      instr_scratch_sel_ff  <= 4'h0;
    end
    else if (p_third && instr_holder_clock_enable)
    begin
      instruction_holder_ff <= nxt_select;
      instr_branch_bits_ff  <= nxt_select[5:3];
      instr_scratch_sel_ff  <= {1'b0, nxt_select[2:0]};
    end
  end
endmodule : mcd_core

// ### verif/mcd_core_assertions.sv
// port-level checks for the microcycle clock and datapath core
// assumes the single clk domain of mcd_core with async active-low rst_n
`timescale 1ns/1ps
module mcd_core_checker
  import mcd_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        running_ff,
  input wire logic        timing_pulse_first_ff,
  input wire logic        timing_pulse_second_ff,
  input wire logic        timing_pulse_third_ff,
  input wire logic        next_cycle_trigger_ff,
  input wire logic        clk_instr_ff,
  input wire logic        clk_bus_address_ff,
  input wire logic        clk_b_operand_ff,
  input wire logic        clk_result_ff,
  input wire logic        wr_scratch_high_ff,
  input wire logic        wr_scratch_low_ff,
  input wire logic [15:0] result_selector_ff,
  input wire logic [15:0] result_reg_ff,
  input wire logic [15:0] sys_bus_data_out_ff,
  input wire logic [15:0] data_display_ff,
  input wire logic        result_zero_ff,
  input wire logic [8:0]  past_microaddress_ff,
  input wire logic [15:0] instruction_holder_ff
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  display_inverse_a: assert property (data_display_ff == ~result_selector_ff)
    else $error("display is not the inverted selector");
  zero_detect_a: assert property (result_zero_ff == (result_reg_ff == 16'h0000))
    else $error("zero detect disagrees with result register");
  bus_data_a: assert property (sys_bus_data_out_ff == result_reg_ff)
    else $error("bus data out differs from result register");
  trigger_third_a: assert property (next_cycle_trigger_ff == timing_pulse_third_ff)
    else $error("trigger not with third pulse");
  pulse_order_a: assert property (timing_pulse_first_ff |->
    !timing_pulse_second_ff && !timing_pulse_third_ff ##1 !timing_pulse_first_ff [*1]
    ##[0:4] timing_pulse_third_ff) else $error("pulses out of order");
  gated_strobe_a: assert property ((clk_instr_ff || clk_bus_address_ff || clk_b_operand_ff ||
    clk_result_ff || wr_scratch_high_ff || wr_scratch_low_ff) |-> timing_pulse_third_ff)
    else $error("gated strobe outside third pulse");
  pulse_running_a: assert property (timing_pulse_first_ff |-> running_ff)
    else $error("pulse while clock stopped");
  result_load_a: assert property (!$stable(result_reg_ff) |-> clk_result_ff || $past(clk_result_ff))
    else $error("result register changed without strobe");
  holder_load_a: assert property (!$stable(instruction_holder_ff) |-> clk_instr_ff ||
    $past(clk_instr_ff)) else $error("instruction holder changed without strobe");
  history_step_a: assert property (!$stable(past_microaddress_ff) |->
    next_cycle_trigger_ff || $past(next_cycle_trigger_ff)) else $error("history moved off trigger");
endmodule : mcd_core_checker

bind mcd_core mcd_core_checker chk_u (.*);

// ### verif/mcd_far_side.sv
// console button and system bus data source facing the core
// assumes the bench raises resume_go for one clock to press the button
`timescale 1ns/1ps
module mcd_far_side
(
  input  wire logic        clk,
  input  wire logic        bus_drive,
  input  wire logic [15:0] bus_word,
  input  wire logic        resume_go,
  output logic [15:0]      sys_bus_data_in,
  output logic             restart_req
);
  logic [2:0] hold_ff;
  initial
  begin
    sys_bus_data_in = 16'h0000;
    restart_req = 1'b0;
    hold_ff = 3'h0;
  end
  always @(negedge clk)
  begin
    // a released bus toggles every clock, so a stale word matches only on every other clock
    sys_bus_data_in <= bus_drive ? bus_word : ~sys_bus_data_in;
    // button held a few clocks so the two-flop sync cannot miss it
    hold_ff <= resume_go ? 3'h5 : (hold_ff != 3'h0 ? hold_ff - 3'h1 : 3'h0);
    restart_req <= resume_go || (hold_ff > 3'h1);
  end
endmodule : mcd_far_side

// ### verif/test_micro_clock_datapath.sv
// self-checking bench for the microcycle clock and datapath core
// assumes the checker is bound to mcd_core and the far side model drives bus and button
`timescale 1ns/1ps
module test_micro_clock_datapath;
  import mcd_pkg::*;
  logic clk, rst_n, maint_mode, restart_req, continue_req, microword_clock_halt, stack_check;
  logic cycle_length_bit0, cycle_length_bit1, instr_holder_clock_enable, result_clock_enable;
  logic bus_address_clock_enable, b_operand_clock_enable, scratch_write_high_byte;
  logic scratch_write_low_byte, resume_go, bus_drive, match_ff, scope_sync_ff, running_ff, idle_ff;
  logic timing_pulse_first_ff, timing_pulse_second_ff, timing_pulse_third_ff, next_cycle_trigger_ff;
  logic clk_instr_ff, clk_bus_address_ff, clk_b_operand_ff, clk_result_ff, wr_scratch_high_ff;
  logic wr_scratch_low_ff, sel_status_ff, sel_stack_limit_ff, sel_scratch_ff, sel_switch_ff;
  logic stack_overflow_stop_ff, stack_overflow_flag_ff, result_zero_ff;
  logic [1:0]  result_sel;
  logic [2:0]  instr_branch_bits_ff;
  logic [3:0]  instr_scratch_sel_ff;
  logic [8:0]  microaddress_pointer, expansion_hi_bits, buffered_microaddress_ff, past_microaddress_ff;
  logic [15:0] console_switch_word, reg_read_bus, alu_out, sys_bus_data_in, stack_pointer, bus_word;
  logic [15:0] result_selector_ff, result_reg_ff, sys_bus_data_out_ff, data_display_ff;
  logic [15:0] instruction_holder_ff, prev_alu, exp_h;
  logic [17:0] bus_address, expansion_microaddress_ff;
  int errors, samples_checked, i, t0;
  logic [17:0] addr_tab [5];

  mcd_core dut_u (.*);
  mcd_far_side far_u (.*);

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out

  // 0 first pulse, 1 result strobe, 2 holder strobe, 3 stopped, 4 running
  task automatic wait_on(input int k);
    int n;
    for (n = 0; n < 60; n++)
    begin
      @(negedge clk);
      if ((k == 0 && timing_pulse_first_ff === 1'b1) || (k == 1 && clk_result_ff === 1'b1) ||
          (k == 2 && clk_instr_ff === 1'b1) || (k == 3 && running_ff === 1'b0) ||
          (k == 4 && running_ff === 1'b1))
        break;
    end
    if (n == 60)
    begin
      errors++;
      close_out();
    end
  endtask : wait_on

  task automatic press(input logic cont);
    continue_req = cont;
    resume_go = !cont;
    @(negedge clk);
    resume_go = 1'b0;
    repeat (4) @(negedge clk);
    continue_req = 1'b0;
    wait_on(4);
  endtask : press

  // r is the result register value that the selector sees in that clock
  function automatic logic [15:0] sel_exp(input logic [1:0] s, input logic [15:0] r);
    case (s)
      SEL_REGBUS: return reg_read_bus;
      SEL_RESULT: return r;
      SEL_SHIFT:  return {1'b0, r[15:1]};
      default:    return bus_word;
    endcase
  endfunction : sel_exp

  function automatic logic [3:0] dec_exp(input logic [17:0] a);
    return {a == ADDR_STATUS, a == ADDR_SLIMIT, (a & ADDR_SPAD_MASK) == ADDR_SPAD_BASE,
            a == ADDR_SWITCH};
  endfunction : dec_exp

  initial
  begin
    void'($urandom(79));
    {rst_n, maint_mode, continue_req, microword_clock_halt, stack_check, resume_go} = '0;
    {cycle_length_bit1, cycle_length_bit0, result_sel, expansion_hi_bits} = '0;
    {instr_holder_clock_enable, result_clock_enable, bus_address_clock_enable} = 3'h7;
    {b_operand_clock_enable, scratch_write_high_byte, scratch_write_low_byte, bus_drive} = 4'hF;
    {microaddress_pointer, console_switch_word, reg_read_bus, alu_out} = '0;
    {stack_pointer, bus_word, bus_address, prev_alu, exp_h} = '0;
    repeat (16) @(negedge clk);
    chk({idle_ff, result_zero_ff, data_display_ff}, {2'h3, 16'hFFFF});
    rst_n = 1'b1;
    press(1'b0);
    for (i = 0; i < 4; i++)
    begin
      {cycle_length_bit1, cycle_length_bit0} = i[1:0];
      wait_on(0);
      wait_on(0);
      t0 = $time;
      wait_on(0);
      chk(($time - t0) / 50, (i == 0) ? LEN_SHORT_CYC : (i == 1) ? LEN_MED_CYC :
          LEN_LONG_CYC);
    end
    for (i = 0; i < 8; i++)
    begin
      alu_out = (i == 7) ? 16'h0000 : 16'($urandom);
      reg_read_bus = 16'($urandom);
      bus_word = 16'($urandom);
      result_sel = i[1:0];
      {bus_address_clock_enable, b_operand_clock_enable, scratch_write_high_byte,
       scratch_write_low_byte} = 4'($urandom);
      wait_on(1);
      chk({clk_bus_address_ff, clk_b_operand_ff, wr_scratch_high_ff, wr_scratch_low_ff},
          {bus_address_clock_enable, b_operand_clock_enable, scratch_write_high_byte,
           scratch_write_low_byte});
      repeat (3) @(negedge clk);
      chk(result_reg_ff, alu_out);
      chk(result_zero_ff, alu_out == 16'h0000);
      chk(result_selector_ff, sel_exp(result_sel, alu_out));
      // the holder loads in the same clock as the result register, so it sees the old result
      exp_h = sel_exp(result_sel, prev_alu);
      chk(instruction_holder_ff, exp_h);
      chk({instr_branch_bits_ff, instr_scratch_sel_ff}, {exp_h[5:3], 1'b0, exp_h[2:0]});
      prev_alu = alu_out;
    end
    for (i = 0; i < 6; i++)
    begin
      microaddress_pointer = 9'($urandom);
      expansion_hi_bits = 9'($urandom);
      console_switch_word = {7'h00, microaddress_pointer ^ ((i % 2) ? 9'h001 << (i % 9) : 9'h000)};
      repeat (16) @(negedge clk);
      chk({match_ff, scope_sync_ff}, {2{(i % 2) == 0}});
      chk(buffered_microaddress_ff, microaddress_pointer);
      chk(expansion_microaddress_ff, {expansion_hi_bits, microaddress_pointer});
      chk(past_microaddress_ff, microaddress_pointer);
    end
    addr_tab = '{ADDR_STATUS, ADDR_SLIMIT, ADDR_SWITCH, ADDR_SPAD_BASE | 18'h00005, 18'($urandom)};
    stack_check = 1'b1;
    for (i = 0; i < 5; i++)
    begin
      bus_address = addr_tab[i];
      stack_pointer = (i < 2) ? 16'h0010 << (i * 4) : 16'($urandom);
      repeat (4) @(negedge clk);
      chk({sel_status_ff, sel_stack_limit_ff, sel_scratch_ff, sel_switch_ff},
          dec_exp(bus_address));
      chk({stack_overflow_flag_ff, stack_overflow_stop_ff}, {stack_pointer < STACK_FLOOR,
          stack_pointer < STACK_FLOOR - STACK_WARN});
    end
    microword_clock_halt = 1'b1;
    wait_on(3);
    microword_clock_halt = 1'b0;
    repeat (12) @(negedge clk);
    chk({running_ff, idle_ff, timing_pulse_first_ff}, 3'h2);
    press(1'b1);
    maint_mode = 1'b1;
    console_switch_word = {7'h00, microaddress_pointer};
    wait_on(3);
    // one drain clock passes between running falling and idle rising
    @(negedge clk);
    chk({running_ff, idle_ff, match_ff, scope_sync_ff}, 4'h6);
    maint_mode = 1'b0;
    close_out();
  end
endmodule : test_micro_clock_datapath
